//--- async_timer_map.svh
// register offsets, field positions, reset values and timing counts of the async timer
`ifndef ASYNC_TIMER_MAP_SVH
`define ASYNC_TIMER_MAP_SVH
// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define OFS_CONTROL        8'h00
`define OFS_COUNTER_VALUE  8'h04
`define OFS_STATUS_FLAGS   8'h08
`define OFS_STATUS_CLEAR   8'h0C
`define OFS_IRQ_EN_SET     8'h10
`define OFS_IRQ_EN_CLEAR   8'h14
`define OFS_IRQ_MASK       8'h18
`define OFS_WAKEUP_ENABLE  8'h1C
`define OFS_MATCH_0        8'h20
`define OFS_MATCH_1        8'h24
`define OFS_TICK_INT_0     8'h30
`define OFS_TICK_INT_1     8'h34
`define OFS_SRC_CLK_CTRL   8'h40
`define OFS_RATE_TRIM      8'h44
`define OFS_EV_EN_SET      8'h48
`define OFS_EV_EN_CLEAR    8'h4C
`define OFS_EV_MASK        8'h50
`define OFS_DATE_TIME      8'h54
`define OFS_MODULE_PARAMS  8'hF0
`define OFS_MODULE_REV     8'hFC
// ************************************************************
// field positions
// ************************************************************
`define CTL_ENABLE_BIT     0
`define CTL_PRESC_RST_BIT  1
`define CTL_CAL_MODE_BIT   2
`define CTL_CLR_MATCH0_BIT 8
`define CTL_CLR_MATCH1_BIT 9
`define CTL_TAP_LSB        16
`define CTL_TAP_MSB        20
`define ST_WRAP_BIT        0
`define ST_MATCH0_BIT      8
`define ST_MATCH1_BIT      9
`define ST_TICK0_BIT       16
`define ST_TICK1_BIT       17
`define ST_BUSY_BIT        24
`define ST_READY_BIT       25
`define ST_CLK_SWITCH_BIT  28
`define ST_CLK_SETTLED_BIT 29
`define CLKCTL_ON_BIT      0
`define TAP_FIELD_MSB      4
// writable masks of the flag-style and control registers, and the reset word
`define FLAG_MASK          32'h2203_0301
`define WAKE_MASK          32'h0003_0301
`define CTL_MASK           32'h001F_0305
`define RESET_WORD         32'h0000_0000
// ************************************************************
// timing counts
// ************************************************************
`define SYNC_BUSY_CYCLES   4'h4
`define CLK_SWITCH_CYCLES  4'h6
`endif

//--- async_timer_pkg.sv
// types of the async timer register block
`default_nettype none
package async_timer_pkg;
  typedef enum logic [2:0] {
    BUS_IDLE  = 3'b001,
    BUS_RESP  = 3'b010,
    BUS_DONE  = 3'b100
  } bus_state_t;
endpackage
`default_nettype wire

//--- async_timer.sv
// async timer register interface with prescaler and 32-bit counter
//
// Added by the designer: the Avalon-MM interface to the registers.
`include "async_timer_map.svh"
`default_nettype none
// Operation
// - counter steps on prescaler bit chosen by control bits 20..16
// - clear-on-match bit n makes match n clear the counter
// - control bit 2 selects counter or calendar mode
// - writing one to control bit 1 resets prescaler; reads zero
// - control bit 0 enables the timer
// - while busy, control and counter writes ignored, reads return zero
// - counter_value reads full 32-bit count and loads on write
// - status bit 24 busy discards writes to synchronized registers
// - ready bit 25 set when busy falls, cleared by status_clear
// - status bit 28 high after clock-on write until clock settles
// - bit 29 set when clock-switching falls, cleared by status_clear
// - tick flag n set on rising edge of selected prescaler bit
// - match flag n set on a tap rise while counter equals match value n
// - wrap flag bit 0 set on overflow, held until cleared
// - status_clear ones clear flags and their requests, zeros ignored
// - status_clear writes dropped while busy
// - irq_enable_set ones set mask bits
// - irq_enable_clear ones clear mask bits
// - request raised only while mask set, held until flag cleared
// - busy held while written values pass into the counter domain
module async_timer
  import async_timer_pkg::*;
#(
  parameter int PRESC_W = 32
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        src_tick_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             irq_o,
  output logic             wake_o,
  output logic      [4:0]  event_o
);

  // ************************************************************
  // source tick synchroniser
  // ************************************************************
  logic [2:0] tick_sync_reg;
  logic       tick_level_reg;
  // change counts once stages two and three agree
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tick_sync_reg  <= 3'h0;
      tick_level_reg <= 1'b0;
    end else begin
      tick_sync_reg <= {tick_sync_reg[1:0], src_tick_i};
      if (tick_sync_reg[1] == tick_sync_reg[2])
        tick_level_reg <= tick_sync_reg[2];
    end
  end
  logic tick_level_d_reg;
  always_ff @(posedge core_clk_i) begin
    if (rst_i)
      tick_level_d_reg <= 1'b0;
    else
      tick_level_d_reg <= tick_level_reg;
  end
  wire src_edge = tick_level_reg & ~tick_level_d_reg;

  // ************************************************************
  // register state
  // ************************************************************
  logic [31:0]        control_reg;
  logic [31:0]        count_reg;
  logic [31:0]        flags_reg;
  logic [31:0]        mask_reg;
  logic [31:0]        wake_en_reg;
  logic [31:0]        ev_mask_reg;
  logic [31:0]        match0_reg, match1_reg;
  logic [4:0]         tap0_reg, tap1_reg;
  logic [31:0]        clk_ctl_reg, trim_reg, date_reg;
  logic [PRESC_W-1:0] presc_reg;
  logic [3:0]         busy_cnt_reg;
  logic [3:0]         clk_cnt_reg;
  logic               busy_d_reg, clk_sw_d_reg;
  bus_state_t         bus_state_reg;

  // ************************************************************
  // bus decode
  // ************************************************************
  wire busy      = (busy_cnt_reg != 4'h0);
  wire clk_sw    = (clk_cnt_reg != 4'h0);
  // writes are taken in idle, so the master sees waitrequest low next cycle
  wire wr_take   = avs_write_i && (bus_state_reg == BUS_IDLE);
  wire rd_take   = avs_read_i && (bus_state_reg == BUS_IDLE);
  wire wr_ok     = wr_take && !busy;
  wire wr_ctl    = wr_ok && (avs_address_i == `OFS_CONTROL);
  wire wr_cnt    = wr_ok && (avs_address_i == `OFS_COUNTER_VALUE);
  wire wr_sclr   = wr_ok && (avs_address_i == `OFS_STATUS_CLEAR);
  wire wr_ien    = wr_take && (avs_address_i == `OFS_IRQ_EN_SET);
  wire wr_idis   = wr_take && (avs_address_i == `OFS_IRQ_EN_CLEAR);
  wire wr_wake   = wr_ok && (avs_address_i == `OFS_WAKEUP_ENABLE);
  wire wr_m0     = wr_ok && (avs_address_i == `OFS_MATCH_0);
  wire wr_m1     = wr_ok && (avs_address_i == `OFS_MATCH_1);
  wire wr_t0     = wr_ok && (avs_address_i == `OFS_TICK_INT_0);
  wire wr_t1     = wr_ok && (avs_address_i == `OFS_TICK_INT_1);
  wire wr_clk    = wr_take && (avs_address_i == `OFS_SRC_CLK_CTRL);
  wire wr_trim   = wr_ok && (avs_address_i == `OFS_RATE_TRIM);
  wire wr_eve    = wr_ok && (avs_address_i == `OFS_EV_EN_SET);
  wire wr_evd    = wr_ok && (avs_address_i == `OFS_EV_EN_CLEAR);
  wire wr_date   = wr_take && (avs_address_i == `OFS_DATE_TIME);
  // any accepted write into the counter domain starts a sync window
  wire sync_go   = wr_ctl | wr_cnt | wr_sclr | wr_wake | wr_m0 | wr_m1 | wr_t0 | wr_t1
                 | wr_trim | wr_eve | wr_evd;

  // ************************************************************
  // prescaler and counter
  // ************************************************************
  wire        enabled   = control_reg[`CTL_ENABLE_BIT];
  wire [4:0]  tap_sel   = control_reg[`CTL_TAP_MSB:`CTL_TAP_LSB];
  wire [PRESC_W-1:0] presc_next = presc_reg + {{(PRESC_W-1){1'b0}}, 1'b1};
  wire        step_pre  = enabled & src_edge;
  // rising edge of a prescaler bit across one increment
  wire        tap_rise  = step_pre & ~presc_reg[tap_sel] & presc_next[tap_sel];
  wire        tick0     = step_pre & ~presc_reg[tap0_reg] & presc_next[tap0_reg];
  wire        tick1     = step_pre & ~presc_reg[tap1_reg] & presc_next[tap1_reg];
  wire        hit0      = tap_rise && (count_reg == match0_reg);
  wire        hit1      = tap_rise && (count_reg == match1_reg);
  wire        clr_hit   = (hit0 & control_reg[`CTL_CLR_MATCH0_BIT])
                        | (hit1 & control_reg[`CTL_CLR_MATCH1_BIT]);
  // wrap counts as overflow, only in counter mode
  wire        wrap      = tap_rise && (count_reg == 32'hFFFF_FFFF) && !control_reg[`CTL_CAL_MODE_BIT];
  // calendar mode holds the plain counter; date register only stores bus writes
  wire        cnt_step  = tap_rise && !control_reg[`CTL_CAL_MODE_BIT];

  always_ff @(posedge core_clk_i) begin
    if (rst_i)
      presc_reg <= '0;
    else if (wr_ctl && avs_writedata_i[`CTL_PRESC_RST_BIT])
      presc_reg <= '0;
    else if (step_pre)
      presc_reg <= presc_next;
  end

  // counter clocked by tap, loaded by write
  always_ff @(posedge core_clk_i) begin
    if (rst_i)
      count_reg <= `RESET_WORD;
    else if (wr_cnt)
      count_reg <= avs_writedata_i;
    else if (clr_hit)
      count_reg <= `RESET_WORD;
    else if (cnt_step)
      count_reg <= count_reg + 32'h0000_0001;
  end

  // enable, mode; reset strobe bit never stored
  always_ff @(posedge core_clk_i) begin
    if (rst_i)
      control_reg <= `RESET_WORD;
    else if (wr_ctl)
      control_reg <= avs_writedata_i & `CTL_MASK;
  end

  // ************************************************************
  // sync windows
  // ************************************************************
  // busy held during transfer
  always_ff @(posedge core_clk_i) begin
    if (rst_i)
      busy_cnt_reg <= 4'h0;
    else if (sync_go)
      busy_cnt_reg <= `SYNC_BUSY_CYCLES;
    else if (busy)
      busy_cnt_reg <= busy_cnt_reg - 4'h1;
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i)
      clk_cnt_reg <= 4'h0;
    else if (wr_clk)
      clk_cnt_reg <= `CLK_SWITCH_CYCLES;
    else if (clk_sw)
      clk_cnt_reg <= clk_cnt_reg - 4'h1;
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      busy_d_reg   <= 1'b0;
      clk_sw_d_reg <= 1'b0;
    end else begin
      busy_d_reg   <= busy;
      clk_sw_d_reg <= clk_sw;
    end
  end

  // ************************************************************
  // status flags
  // ************************************************************
  logic [31:0] flag_set;
  always_comb begin
    flag_set = 32'h0;
    // wrap flag, also set by clear-on-match
    flag_set[`ST_WRAP_BIT]        = wrap | clr_hit;
    flag_set[`ST_MATCH0_BIT]      = hit0;
    flag_set[`ST_MATCH1_BIT]      = hit1;
    flag_set[`ST_TICK0_BIT]       = tick0;
    flag_set[`ST_TICK1_BIT]       = tick1;
    flag_set[`ST_READY_BIT]       = busy_d_reg & ~busy;
    flag_set[`ST_CLK_SETTLED_BIT] = clk_sw_d_reg & ~clk_sw;
  end
  wire [31:0] flag_clr = wr_sclr ? (avs_writedata_i & `FLAG_MASK) : 32'h0;
  // ones clear, set wins over clear
  always_ff @(posedge core_clk_i) begin
    if (rst_i)
      flags_reg <= `RESET_WORD;
    else
      flags_reg <= (flags_reg & ~flag_clr) | flag_set;
  end

  // mask set and clear, set wins on same write
  always_ff @(posedge core_clk_i) begin
    if (rst_i)
      mask_reg <= `RESET_WORD;
    else if (wr_ien)
      mask_reg <= mask_reg | (avs_writedata_i & `FLAG_MASK);
    else if (wr_idis)
      mask_reg <= mask_reg & ~avs_writedata_i;
  end

  // event mask and wake enable
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ev_mask_reg <= `RESET_WORD;
      wake_en_reg <= `RESET_WORD;
    end else begin
      if (wr_eve)
        ev_mask_reg <= ev_mask_reg | (avs_writedata_i & `WAKE_MASK);
      else if (wr_evd)
        ev_mask_reg <= ev_mask_reg & ~avs_writedata_i;
      if (wr_wake)
        wake_en_reg <= avs_writedata_i & `WAKE_MASK;
    end
  end

  // plain storage registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      match0_reg  <= `RESET_WORD;
      match1_reg  <= `RESET_WORD;
      tap0_reg    <= 5'h00;
      tap1_reg    <= 5'h00;
      clk_ctl_reg <= `RESET_WORD;
      trim_reg    <= `RESET_WORD;
      date_reg    <= `RESET_WORD;
    end else begin
      if (wr_m0) match0_reg <= avs_writedata_i;
      if (wr_m1) match1_reg <= avs_writedata_i;
      if (wr_t0) tap0_reg <= avs_writedata_i[`TAP_FIELD_MSB:0];
      if (wr_t1) tap1_reg <= avs_writedata_i[`TAP_FIELD_MSB:0];
      if (wr_clk) clk_ctl_reg <= avs_writedata_i;
      if (wr_trim) trim_reg <= avs_writedata_i;
      if (wr_date) date_reg <= avs_writedata_i;
    end
  end

  // ************************************************************
  // read mux and bus handshake
  // ************************************************************
  logic [31:0] status_word;
  always_comb begin
    status_word = flags_reg;
    status_word[`ST_BUSY_BIT]       = busy;
    status_word[`ST_CLK_SWITCH_BIT] = clk_sw;
  end
  // synced registers except the event mask read zero while busy
  logic [31:0] rd_mux;
  always_comb begin
    case (avs_address_i)
      `OFS_CONTROL:       rd_mux = busy ? 32'h0 : control_reg;
      `OFS_COUNTER_VALUE: rd_mux = busy ? 32'h0 : count_reg;
      `OFS_STATUS_FLAGS:  rd_mux = status_word;
      `OFS_IRQ_MASK:      rd_mux = mask_reg;
      `OFS_WAKEUP_ENABLE: rd_mux = busy ? 32'h0 : wake_en_reg;
      `OFS_MATCH_0:       rd_mux = busy ? 32'h0 : match0_reg;
      `OFS_MATCH_1:       rd_mux = busy ? 32'h0 : match1_reg;
      `OFS_TICK_INT_0:    rd_mux = busy ? 32'h0 : {27'h0, tap0_reg};
      `OFS_TICK_INT_1:    rd_mux = busy ? 32'h0 : {27'h0, tap1_reg};
      `OFS_SRC_CLK_CTRL:  rd_mux = clk_ctl_reg;
      `OFS_RATE_TRIM:     rd_mux = busy ? 32'h0 : trim_reg;
      `OFS_EV_MASK:       rd_mux = ev_mask_reg;
      `OFS_DATE_TIME:     rd_mux = date_reg;
      default:            rd_mux = 32'h0;
    endcase
  end
  bus_state_t bus_state_next;
  always_comb begin
    case (bus_state_reg)
      BUS_IDLE: bus_state_next = (rd_take | wr_take) ? BUS_RESP : BUS_IDLE;
      BUS_RESP: bus_state_next = BUS_DONE;
      BUS_DONE: bus_state_next = BUS_IDLE;
      default:  bus_state_next = BUS_IDLE;
    endcase
  end
  // answer one cycle after take; resp and done states keep the held request from retriggering
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      bus_state_reg     <= BUS_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0;
    end else begin
      bus_state_reg     <= bus_state_next;
      avs_waitrequest_o <= !((rd_take | wr_take));
      if (rd_take)
        avs_readdata_o <= rd_mux;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // request while mask and flag both set
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_o   <= 1'b0;
      wake_o  <= 1'b0;
      event_o <= 5'h00;
    end else begin
      irq_o   <= |(flags_reg & mask_reg);
      wake_o  <= |(flags_reg & wake_en_reg);
      event_o <= {flag_set[`ST_TICK1_BIT] & ev_mask_reg[`ST_TICK1_BIT],
                  flag_set[`ST_TICK0_BIT] & ev_mask_reg[`ST_TICK0_BIT],
                  flag_set[`ST_MATCH1_BIT] & ev_mask_reg[`ST_MATCH1_BIT],
                  flag_set[`ST_MATCH0_BIT] & ev_mask_reg[`ST_MATCH0_BIT],
                  flag_set[`ST_WRAP_BIT] & ev_mask_reg[`ST_WRAP_BIT]};
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  property p_busy_after_write;
    @(posedge core_clk_i) disable iff (rst_i)
    sync_go |=> busy [*4] ##1 !busy;
  endproperty
  a_busy_after_write: assert property (p_busy_after_write) else $error("busy window wrong");
  property p_ready_on_fall;
    @(posedge core_clk_i) disable iff (rst_i)
    ($fell(busy) && !wr_sclr) |=> flags_reg[`ST_READY_BIT];
  endproperty
  a_ready_on_fall: assert property (p_ready_on_fall) else $error("ready not set");
  property p_clk_settled;
    @(posedge core_clk_i) disable iff (rst_i)
    wr_clk |=> clk_sw [*6] ##1 !clk_sw ##1 flags_reg[`ST_CLK_SETTLED_BIT];
  endproperty
  a_clk_settled: assert property (p_clk_settled) else $error("clock settle wrong");
  property p_busy_drops_ctl;
    @(posedge core_clk_i) disable iff (rst_i)
    (wr_take && busy && avs_address_i == `OFS_CONTROL) |=> $stable(control_reg);
  endproperty
  a_busy_drops_ctl: assert property (p_busy_drops_ctl) else $error("control written while busy");
  property p_count_load;
    @(posedge core_clk_i) disable iff (rst_i)
    wr_cnt |=> count_reg == $past(avs_writedata_i);
  endproperty
  a_count_load: assert property (p_count_load) else $error("count not loaded");
  property p_wrap_flag;
    @(posedge core_clk_i) disable iff (rst_i)
    (wrap && !wr_cnt) |=> flags_reg[`ST_WRAP_BIT] && count_reg == 32'h0;
  endproperty
  a_wrap_flag: assert property (p_wrap_flag) else $error("wrap not flagged");
  property p_match_clear;
    @(posedge core_clk_i) disable iff (rst_i)
    (hit0 && control_reg[`CTL_CLR_MATCH0_BIT] && !wr_cnt) |=> count_reg == 32'h0;
  endproperty
  a_match_clear: assert property (p_match_clear) else $error("match did not clear");
  property p_irq_mask;
    @(posedge core_clk_i) disable iff (rst_i)
    (mask_reg == 32'h0) |=> !irq_o;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq without mask");
  property p_ctl_read_zero;
    @(posedge core_clk_i) disable iff (rst_i)
    (rd_take && busy && avs_address_i == `OFS_CONTROL) |=> avs_readdata_o == 32'h0 && !avs_waitrequest_o;
  endproperty
  a_ctl_read_zero: assert property (p_ctl_read_zero) else $error("busy read not zero");
  c_wrap: cover property (@(posedge core_clk_i) disable iff (rst_i) wrap);
  c_hit1: cover property (@(posedge core_clk_i) disable iff (rst_i) hit1);
  c_irq:  cover property (@(posedge core_clk_i) disable iff (rst_i) $rose(irq_o));

endmodule // async_timer
`default_nettype wire

//--- async_timer_tb.sv
// self-checking testbench of the async timer register block
`include "async_timer_map.svh"
`default_nettype none
module async_timer_tb
  import async_timer_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk_i;
  logic        rst_i;
  logic        src_tick_i;
  logic [7:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        irq_o;
  logic        wake_o;
  logic [4:0]  event_o;
  logic [31:0] q;
  logic [4:0]  ev_seen;
  int          error_cnt;
  int          n_tests;

  async_timer uut (
    .core_clk_i        (core_clk_i),
    .rst_i             (rst_i),
    .src_tick_i        (src_tick_i),
    .avs_address_i     (avs_address_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_writedata_i   (avs_writedata_i),
    .avs_readdata_o    (avs_readdata_o),
    .avs_waitrequest_o (avs_waitrequest_o),
    .irq_o             (irq_o),
    .wake_o            (wake_o),
    .event_o           (event_o)
  );

  // ************************************************************
  // clock, closing and watchdog
  // ************************************************************
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end

  // event pulses last one cycle, so keep a sticky record of them
  always @(posedge core_clk_i) begin
    ev_seen <= rst_i ? 5'h00 : (ev_seen | event_o);
  end

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // whole run needs a few hundred cycles; this is ample
  initial begin
    repeat (20000) @(posedge core_clk_i);
    error_cnt++;
    report_and_stop();
  end

  // ************************************************************
  // bus master and helpers
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // request held until waitrequest is seen low at a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge core_clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= wr;
    avs_read_i      <= ~wr;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    r = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    chk({31'h0, n < 50}, 32'h1, "bus answer");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    xfer(1'b0, a, 32'h0000_0000, r);
  endtask

  // polls status until busy drops; hands back the last status word
  task automatic wait_idle(output logic [31:0] st);
    int n;
    n = 0;
    do begin
      rd(`OFS_STATUS_FLAGS, st);
      n++;
    end while (st[24] !== 1'b0 && n < 20);
    chk({31'h0, n < 20}, 32'h1, "busy release");
  endtask

  // source level slow enough for the three-flop synchronizer
  task automatic src_pulses(input int n);
    repeat (n) begin
      src_tick_i <= 1'b1;
      repeat (8) @(posedge core_clk_i);
      src_tick_i <= 1'b0;
      repeat (8) @(posedge core_clk_i);
    end
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic test_reset;
    logic [7:0] ofs [10];
    ofs = '{`OFS_CONTROL, `OFS_COUNTER_VALUE, `OFS_STATUS_FLAGS, `OFS_IRQ_MASK, `OFS_WAKEUP_ENABLE,
            `OFS_MATCH_0, `OFS_TICK_INT_1, `OFS_EV_MASK, `OFS_DATE_TIME, 8'h60};
    wr(8'h60, 32'hFFFF_FFFF);
    foreach (ofs[i]) begin
      rd(ofs[i], q);
      chk(q, 32'h0000_0000, "reset value");
    end
    $display("test reset done");
  endtask

  task automatic test_control;
    logic [31:0] st;
    wr(`OFS_CONTROL, 32'h001F_0307);
    rd(`OFS_CONTROL, q);
    chk(q, 32'h0000_0000, "read while busy");
    wait_idle(st);
    rd(`OFS_CONTROL, q);
    chk(q, 32'h001F_0305, "control fields");
    wr(`OFS_MATCH_0, 32'h0000_0002);
    rd(`OFS_STATUS_FLAGS, q);
    chk(q & 32'h0100_0000, 32'h0100_0000, "busy after write");
    wait_idle(st);
    chk(st & 32'h0200_0000, 32'h0200_0000, "ready on busy fall");
    wr(`OFS_COUNTER_VALUE, 32'h1234_5678);
    wr(`OFS_COUNTER_VALUE, 32'h0BAD_F00D);
    wait_idle(st);
    rd(`OFS_COUNTER_VALUE, q);
    chk(q, 32'h1234_5678, "second write discarded");
    $display("test control done");
  endtask

  task automatic test_count;
    logic [31:0] st;
    wr(`OFS_COUNTER_VALUE, 32'hFFFF_FFFF);
    wait_idle(st);
    wr(`OFS_CONTROL, 32'h0000_0003);
    wait_idle(st);
    wr(`OFS_EV_EN_SET, 32'h0003_0301);
    wait_idle(st);
    src_pulses(8);
    wait_idle(st);
    rd(`OFS_COUNTER_VALUE, q);
    chk(q, 32'h0000_0003, "count after wrap");
    chk(st & 32'h0003_0301, 32'h0003_0301, "wrap match tick flags");
    chk({27'h0, ev_seen}, 32'h0000_001F, "events seen");
    // match at 4 with clear-on-match 0: two tap rises take 3 to 4, then clear
    wr(`OFS_MATCH_0, 32'h0000_0004);
    wait_idle(st);
    wr(`OFS_CONTROL, 32'h0000_0101);
    wait_idle(st);
    src_pulses(4);
    wait_idle(st);
    rd(`OFS_COUNTER_VALUE, q);
    chk(q, 32'h0000_0000, "cleared on match");
    $display("test count done");
  endtask

  task automatic test_irq;
    logic [31:0] st;
    wr(`OFS_WAKEUP_ENABLE, 32'h0000_0001);
    wait_idle(st);
    chk({31'h0, wake_o}, 32'h1, "wake raised");
    wr(`OFS_IRQ_EN_SET, 32'h0000_0001);
    rd(`OFS_IRQ_MASK, q);
    chk(q, 32'h0000_0001, "mask set");
    chk({31'h0, irq_o}, 32'h1, "request raised");
    wr(`OFS_CONTROL, 32'h0000_0001);
    wr(`OFS_STATUS_CLEAR, 32'h0000_0100);
    wait_idle(st);
    wr(`OFS_STATUS_CLEAR, 32'h0000_0001);
    wait_idle(st);
    chk(st & 32'h0000_0101, 32'h0000_0100, "clear one flag only");
    chk({31'h0, irq_o}, 32'h0, "request dropped");
    chk({31'h0, wake_o}, 32'h0, "wake dropped");
    wr(`OFS_IRQ_EN_CLEAR, 32'h0000_0001);
    rd(`OFS_IRQ_MASK, q);
    chk(q, 32'h0000_0000, "mask cleared");
    $display("test irq done");
  endtask

  task automatic test_clock;
    wr(`OFS_SRC_CLK_CTRL, 32'h0000_0001);
    rd(`OFS_STATUS_FLAGS, q);
    chk(q & 32'h3000_0000, 32'h1000_0000, "clock switching");
    repeat (10) @(posedge core_clk_i);
    rd(`OFS_STATUS_FLAGS, q);
    chk(q & 32'h3000_0000, 32'h2000_0000, "clock settled");
    $display("test clock done");
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    error_cnt       = 0;
    n_tests         = 0;
    rst_i           = 1'b1;
    src_tick_i      = 1'b0;
    avs_address_i   = 8'h00;
    avs_read_i      = 1'b0;
    avs_write_i     = 1'b0;
    avs_writedata_i = 32'h0000_0000;
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'b0;
    test_reset();
    test_control();
    test_count();
    test_irq();
    test_clock();
    report_and_stop();
  end
endmodule // async_timer_tb
`default_nettype wire
